// ===== logic/vcr_regs.svh
// Register offsets, field positions, reset values and fixed codes of the VC resource 0 register bank
`ifndef VCR_REGS_SVH
`define VCR_REGS_SVH

// Byte offsets inside the port configuration space
`define VCR_ADDR_W 12
`define VCR_CAP_OFF 12'h210
`define VCR_CTL_OFF 12'h214
`define VCR_STS_OFF 12'h218
`define VCR_TBL_OFF 12'h220

// Capability fields
`define VCR_CAP_ARBCAP_LSB 0
`define VCR_CAP_SLOTS_LSB 16
`define VCR_CAP_TBLOFF_LSB 24
`define VCR_ARBCAP_UP 8'h03
`define VCR_ARBCAP_DN 8'h01
`define VCR_SLOTS_VAL 7'h00
`define VCR_TBLOFF_UP 8'h02
`define VCR_TBLOFF_DN 8'h00

// Control fields
`define VCR_CTL_TCMAP_LSB 0
`define VCR_CTL_LOAD_BIT 16
`define VCR_CTL_SEL_LSB 17
`define VCR_CTL_CHID_LSB 24
`define VCR_CTL_CHEN_BIT 31
`define VCR_TCMAP_RST 8'hFF
`define VCR_TCMAP_WMASK 8'hFE
`define VCR_SEL_RST 3'h0
`define VCR_CHID_VAL 3'h0
`define VCR_CHEN_VAL 1'b1

// Status fields
`define VCR_STS_TBLSTS_BIT 0

// Arbitration table
`define VCR_TBL_WORDS 4
`define VCR_TBL_RST 32'h1765_4321

`endif

// ===== logic/vcr_pkg.sv
// Types shared by the VC resource 0 register bank
`default_nettype none
package vcr_pkg;

    // APB request from the configuration master
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
        logic [3:0] pstrb;
    } vcr_apb_req_t;

    // Register selected by an address
    typedef enum logic [2:0] {
        SEL_NONE = 3'h0,
        SEL_CAP = 3'h1,
        SEL_CTL = 3'h2,
        SEL_STS = 3'h3,
        SEL_TBL = 3'h4
    } vcr_reg_sel_t;

    // Table loader sequence, Gray coded
    typedef enum logic [1:0] {
        LD_IDLE = 2'b00,
        LD_COPY = 2'b01,
        LD_DONE = 2'b11
    } vcr_load_state_t;

endpackage : vcr_pkg
`default_nettype wire

// ===== logic/vcr_apb_slave.sv
// APB handshake timing: one wait state, commit and sample strobes
`timescale 1ns/100ps
`default_nettype none
module vcr_apb_slave
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic ce,
    // Bus request
    input wire vcr_pkg::vcr_apb_req_t apb_req,
    // Handshake
    output logic pready_r,
    output logic sample,
    output logic commit
);
    import vcr_pkg::*;

    // Sample in the first access cycle, commit at the edge that sees pready
    assign sample = ce & apb_req.psel & apb_req.penable & ~pready_r;
    assign commit = ce & apb_req.psel & apb_req.penable & pready_r;

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            pready_r <= 1'b0;
        else if (ce)
            pready_r <= apb_req.psel & apb_req.penable & ~pready_r;
    end

endmodule : vcr_apb_slave
`default_nettype wire

// ===== logic/vcr_table_loader.sv
// Sequencer that copies the arbitration table into the arbiter word by word
`timescale 1ns/100ps
`default_nettype none
module vcr_table_loader
#(
    parameter int DEPTH = 4,
    parameter int IDX_W = 2
)
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic ce,
    // Control
    input wire logic start,
    output logic busy,
    output logic done,
    // Copy strobe
    output logic copy_en,
    output logic [IDX_W-1:0] copy_idx
);
    import vcr_pkg::*;

    vcr_load_state_t state_r;
    vcr_load_state_t state_nxt;
    logic [IDX_W-1:0] idx_r;

    localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(DEPTH - 1);

    assign busy = (state_r != LD_IDLE);
    assign done = ce & (state_r == LD_DONE);
    assign copy_en = ce & (state_r == LD_COPY);
    assign copy_idx = idx_r;

    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            LD_IDLE:
                if (start)
                    state_nxt = LD_COPY;
            LD_COPY:
                if (idx_r == LAST_IDX)
                    state_nxt = LD_DONE;
            LD_DONE:
                state_nxt = LD_IDLE;
            default:
                state_nxt = LD_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            state_r <= LD_IDLE;
        else if (ce)
            state_r <= state_nxt;
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            idx_r <= '0;
        else if (ce)
        begin
            if (state_r != LD_COPY)
                idx_r <= '0;
            else if (idx_r != LAST_IDX)
                idx_r <= idx_r + 1'b1;
        end
    end

endmodule : vcr_table_loader
`default_nettype wire

// ===== logic/vcr_bank.sv
// VC resource 0 capability, control, status and arbitration table registers on APB
`include "vcr_regs.svh"
`timescale 1ns/100ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
//
// Contract
// - Maximum time-slot field reads zero; time-based weighted round robin unsupported.
// - Table offset field reads 0x2 upstream, 0x0 downstream, in 16-byte units.
// - Only the upstream port has an arbitration table; downstream has none.
// - Traffic-class map resets to 0xFF; bit 0 read-only, bits 1-7 writable.
// - Writing one to load bit copies the table into the arbiter.
// - Writing zero to load bit does nothing; the bit always reads zero.
// - Load trigger acts only on the upstream port.
// - Load acts only when the selected scheme uses the table.
// - Three-bit scheme select resets zero, is writable, and drives the arbiter.
// - Channel identifier field is read-only and fixed at zero.
// - Channel enable bit is read-only and fixed at one.
// - Table status sets on table writes, clears at load end, zero downstream.
// - Capability bit 0 fixed round robin, bit 1 WRR32; 0x3 up, 0x1 down.
module vcr_bank
#(
    parameter bit IS_UPSTREAM = 1'b1,
    parameter int TBL_WORDS = `VCR_TBL_WORDS,
    parameter logic [31:0] TBL_RST = `VCR_TBL_RST
)
(
    // Clock, reset, enable
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic ce,
    // APB slave
    input wire vcr_pkg::vcr_apb_req_t apb_req,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // Arbiter configuration
    output logic [7:0] traffic_class_map,
    output logic [2:0] arb_scheme_select,
    output logic [TBL_WORDS*32-1:0] arb_table_active,
    output logic arb_table_status,
    output logic load_busy
);
    import vcr_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Constants

    localparam int IDX_W = (TBL_WORDS > 1) ? $clog2(TBL_WORDS) : 1;
    localparam logic [11:0] TBL_END = 12'(`VCR_TBL_OFF + 4 * TBL_WORDS);

    localparam logic [7:0] ARB_CAPABILITY = IS_UPSTREAM ? `VCR_ARBCAP_UP : `VCR_ARBCAP_DN;
    localparam logic [7:0] ARB_TABLE_OFFSET = IS_UPSTREAM ? `VCR_TBLOFF_UP : `VCR_TBLOFF_DN;

    ////////////////////////////////////////////////////////////////////////////
    // Functions

    // Address to register; misaligned and absent addresses map to nothing
    function automatic vcr_reg_sel_t decode(input logic [11:0] addr);
        vcr_reg_sel_t sel;
        sel = SEL_NONE;
        if (addr[1:0] == 2'b00)
        begin
            if (addr == `VCR_CAP_OFF)
                sel = SEL_CAP;
            else if (addr == `VCR_CTL_OFF)
                sel = SEL_CTL;
            else if (addr == `VCR_STS_OFF)
                sel = SEL_STS;
            else if (IS_UPSTREAM && addr >= `VCR_TBL_OFF && addr < TBL_END)
                sel = SEL_TBL;
        end
        return sel;
    endfunction : decode

    // Byte-lane merge of a write into a stored word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wdata,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++)
        begin
            if (strb[b])
                res[b*8 +: 8] = wdata[b*8 +: 8];
        end
        return res;
    endfunction : merge

    // True when the scheme is advertised and needs the table
    function automatic logic uses_table(input logic [2:0] sel);
        return (sel != 3'h0) && ARB_CAPABILITY[sel];
    endfunction : uses_table

    // Table word index from a byte address
    function automatic logic [IDX_W-1:0] tbl_index(input logic [11:0] addr);
        logic [11:0] rel;
        rel = addr - `VCR_TBL_OFF;
        return rel[IDX_W+1:2];
    endfunction : tbl_index

    ////////////////////////////////////////////////////////////////////////////
    // Storage

    logic [7:0] tc_map_r;
    logic [2:0] scheme_r;
    logic [31:0] tbl_mem [TBL_WORDS];
    logic [31:0] active_r [TBL_WORDS];
    logic status_r;
    logic [31:0] prdata_r;
    logic pslverr_r;
    logic busy_r;

    ////////////////////////////////////////////////////////////////////////////
    // Bus handshake

    logic pready_r;
    logic sample;
    logic commit;
    vcr_reg_sel_t acc_sel;
    logic [IDX_W-1:0] acc_idx;
    logic wr_commit;
    logic [31:0] wr_data;

    vcr_apb_slave u_apb
    (
        .clk_sys (clk_sys),
        .resetn (resetn),
        .ce (ce),
        .apb_req (apb_req),
        .pready_r (pready_r),
        .sample (sample),
        .commit (commit)
    );

    assign acc_sel = decode(apb_req.paddr);
    assign acc_idx = tbl_index(apb_req.paddr);
    assign wr_commit = commit & apb_req.pwrite;
    assign wr_data = apb_req.pwdata;

    ////////////////////////////////////////////////////////////////////////////
    // Write decode

    logic ctl_wr;
    logic tbl_wr;
    logic [31:0] ctl_merged;
    logic load_req;
    logic load_start;

    assign ctl_wr = wr_commit & (acc_sel == SEL_CTL);
    assign tbl_wr = wr_commit & (acc_sel == SEL_TBL);

    // only byte lanes present update, reserved bits are never stored
    assign ctl_merged = merge(32'h0000_0000, wr_data, apb_req.pstrb);

    // a zero on the load bit is simply not a request
    assign load_req = ctl_wr & apb_req.pstrb[2] & ctl_merged[`VCR_CTL_LOAD_BIT];

    // gated by the scheme already in force before this write
    assign load_start = IS_UPSTREAM & load_req & uses_table(scheme_r) & ~busy_r;

    ////////////////////////////////////////////////////////////////////////////
    // Control register

    // bit 0 stays set, bits 1-7 follow writes
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            tc_map_r <= `VCR_TCMAP_RST;
        else if (ce && ctl_wr && apb_req.pstrb[0])
            tc_map_r <= (wr_data[7:0] & `VCR_TCMAP_WMASK) | (`VCR_TCMAP_RST & ~`VCR_TCMAP_WMASK);
    end

    // scheme select is a plain writable field
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            scheme_r <= `VCR_SEL_RST;
        else if (ce && ctl_wr && apb_req.pstrb[2])
            scheme_r <= wr_data[`VCR_CTL_SEL_LSB +: 3];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Arbitration table

    // written only through an address that decodes on the upstream port
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            for (int i = 0; i < TBL_WORDS; i++)
                tbl_mem[i] <= TBL_RST;
        end
        else if (ce && tbl_wr)
            tbl_mem[acc_idx] <= merge(tbl_mem[acc_idx], wr_data, apb_req.pstrb);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Table load into the arbiter

    logic ld_busy;
    logic ld_done;
    logic ld_copy;
    logic [IDX_W-1:0] ld_idx;

    vcr_table_loader
    #(
        .DEPTH (TBL_WORDS),
        .IDX_W (IDX_W)
    )
    u_loader
    (
        .clk_sys (clk_sys),
        .resetn (resetn),
        .ce (ce),
        .start (load_start),
        .busy (ld_busy),
        .done (ld_done),
        .copy_en (ld_copy),
        .copy_idx (ld_idx)
    );

    // copy one word per cycle; a word written mid-load is taken if not yet copied
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            for (int i = 0; i < TBL_WORDS; i++)
                active_r[i] <= TBL_RST;
        end
        else if (ce && ld_copy)
            active_r[ld_idx] <= tbl_mem[ld_idx];
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            busy_r <= 1'b0;
        else if (ce)
            busy_r <= load_start | (ld_busy & ~ld_done);
    end

    // a table write wins over the load end in the same cycle
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            status_r <= 1'b0;
        else if (ce)
        begin
            if (!IS_UPSTREAM)
                status_r <= 1'b0;
            else if (tbl_wr)
                status_r <= 1'b1;
            else if (ld_done)
                status_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data

    logic [31:0] cap_word;
    logic [31:0] ctl_word;
    logic [31:0] sts_word;
    logic [31:0] rd_word;

    // time-slot field fixed, reserved bits zero
    always_comb
    begin
        cap_word = 32'h0000_0000;
        cap_word[`VCR_CAP_ARBCAP_LSB +: 8] = ARB_CAPABILITY;
        cap_word[`VCR_CAP_SLOTS_LSB +: 7] = `VCR_SLOTS_VAL;
        cap_word[`VCR_CAP_TBLOFF_LSB +: 8] = ARB_TABLE_OFFSET;
    end

    always_comb
    begin
        ctl_word = 32'h0000_0000;
        ctl_word[`VCR_CTL_TCMAP_LSB +: 8] = tc_map_r;
        ctl_word[`VCR_CTL_SEL_LSB +: 3] = scheme_r;
        ctl_word[`VCR_CTL_CHID_LSB +: 3] = `VCR_CHID_VAL;
        ctl_word[`VCR_CTL_CHEN_BIT] = `VCR_CHEN_VAL;
    end

    // software polls this bit after a load
    always_comb
    begin
        sts_word = 32'h0000_0000;
        sts_word[`VCR_STS_TBLSTS_BIT] = status_r;
    end

    always_comb
    begin
        case (acc_sel)
            SEL_CAP: rd_word = cap_word;
            SEL_CTL: rd_word = ctl_word;
            SEL_STS: rd_word = sts_word;
            SEL_TBL: rd_word = tbl_mem[acc_idx];
            default: rd_word = 32'h0000_0000;
        endcase
    end

    // Read data and error are captured a cycle early so they stand with pready
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            prdata_r <= 32'h0000_0000;
        else if (ce && sample)
            prdata_r <= apb_req.pwrite ? 32'h0000_0000 : rd_word;
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            pslverr_r <= 1'b0;
        else if (ce && sample)
            pslverr_r <= (acc_sel == SEL_NONE);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign pready = pready_r;
    assign prdata = prdata_r;
    assign pslverr = pslverr_r;
    assign traffic_class_map = tc_map_r;
    assign arb_scheme_select = scheme_r;
    assign arb_table_status = status_r;
    assign load_busy = busy_r;

    // Flatten the arbiter copy for the datapath
    always_comb
    begin
        arb_table_active = '0;
        for (int i = 0; i < TBL_WORDS; i++)
            arb_table_active[i*32 +: 32] = active_r[i];
    end

endmodule : vcr_bank
`default_nettype wire

// ===== dv/vcr_bank_monitor.sv
// Concurrent checks on the VC resource 0 register bank ports
`include "vcr_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module vcr_bank_monitor
#(
    parameter bit IS_UPSTREAM = 1'b1,
    parameter int TBL_WORDS = 4,
    parameter logic [31:0] TBL_RST = 32'h1765_4321
)
(
    // Clock, reset, enable
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic ce,
    // APB slave
    input wire vcr_pkg::vcr_apb_req_t apb_req,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    // Arbiter configuration
    input wire logic [7:0] traffic_class_map,
    input wire logic [2:0] arb_scheme_select,
    input wire logic [TBL_WORDS*32-1:0] arb_table_active,
    input wire logic arb_table_status,
    input wire logic load_busy
);
    import vcr_pkg::*;
    localparam int LD_MAX = TBL_WORDS + 4;
    localparam logic [31:0] CAP_VAL = IS_UPSTREAM ? 32'h0200_0003 : 32'h0000_0001;
    wire logic acc = pready && !pslverr && ce;
    wire logic ctl = apb_req.paddr == `VCR_CTL_OFF;
    wire logic tbl = apb_req.paddr >= `VCR_TBL_OFF && apb_req.paddr < `VCR_TBL_OFF + 12'(TBL_WORDS * 4);
    wire logic ctl_wr = acc && apb_req.pwrite && ctl;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);

    property p_ready_once;
        pready && ce |=> !pready;
    endproperty
    a_ready_once: assert property (p_ready_once) else $error("ready held two cycles");
    property p_ready_wait;
        apb_req.psel && apb_req.penable && !pready && ce |=> pready;
    endproperty
    a_ready_wait: assert property (p_ready_wait) else $error("ready not after one wait state");
    property p_cap_read;
        acc && !apb_req.pwrite && apb_req.paddr == `VCR_CAP_OFF |-> prdata == CAP_VAL;
    endproperty
    a_cap_read: assert property (p_cap_read) else $error("capability read wrong");
    property p_ctl_fixed;
        acc && !apb_req.pwrite && ctl |-> prdata == {1'b1, 11'h000, arb_scheme_select, 9'h000, traffic_class_map};
    endproperty
    a_ctl_fixed: assert property (p_ctl_fixed) else $error("control read wrong");
    property p_sel_write;
        ctl_wr && apb_req.pstrb[2] |=> arb_scheme_select == $past(apb_req.pwdata[19:17]);
    endproperty
    a_sel_write: assert property (p_sel_write) else $error("scheme select not stored");
    property p_map_write;
        ctl_wr && apb_req.pstrb[0] |=> traffic_class_map == {$past(apb_req.pwdata[7:1]), 1'b1};
    endproperty
    a_map_write: assert property (p_map_write) else $error("tc map not stored");
    property p_load_start;
        ctl_wr && apb_req.pstrb[2] && apb_req.pwdata[16] && arb_scheme_select == 3'h1 && !load_busy
            && IS_UPSTREAM |-> ##[1:2] load_busy;
    endproperty
    a_load_start: assert property (p_load_start) else $error("load did not start");
    property p_load_end;
        $rose(load_busy) |-> ##[1:LD_MAX] !load_busy;
    endproperty
    a_load_end: assert property (p_load_end) else $error("load never ended");
    property p_down_idle;
        !IS_UPSTREAM |-> !load_busy && !arb_table_status;
    endproperty
    a_down_idle: assert property (p_down_idle) else $error("downstream load or status");
    property p_active_hold;
        !load_busy && !$past(load_busy) |-> $stable(arb_table_active);
    endproperty
    a_active_hold: assert property (p_active_hold) else $error("active table changed idle");
    property p_status_set;
        acc && apb_req.pwrite && tbl && apb_req.pstrb != 4'h0 && IS_UPSTREAM |=> arb_table_status;
    endproperty
    a_status_set: assert property (p_status_set) else $error("table status not set");
    property p_hold_off;
        !ce |=> $stable(pready) && $stable(prdata) && $stable(traffic_class_map) && $stable(arb_scheme_select);
    endproperty
    a_hold_off: assert property (p_hold_off) else $error("state moved with enable low");

    c_load: cover property (load_busy ##1 !load_busy);
    c_tbl_write: cover property (acc && apb_req.pwrite && tbl);
    c_error: cover property (pready && pslverr);
endmodule : vcr_bank_monitor

bind vcr_bank vcr_bank_monitor #(.IS_UPSTREAM(IS_UPSTREAM), .TBL_WORDS(TBL_WORDS), .TBL_RST(TBL_RST))
    u_vcr_bank_monitor (.clk_sys(clk_sys), .resetn(resetn), .ce(ce), .apb_req(apb_req), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .traffic_class_map(traffic_class_map),
    .arb_scheme_select(arb_scheme_select), .arb_table_active(arb_table_active),
    .arb_table_status(arb_table_status), .load_busy(load_busy));
`default_nettype wire

// ===== dv/tb.sv
// Self-checking bench for the VC resource 0 register bank, one upstream and one downstream port
`include "vcr_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module tb;
    import vcr_pkg::*;
    localparam int TW = 4;
    localparam logic [31:0] RST = 32'h1765_4321;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic ce = 1'b1;
    vcr_apb_req_t req = '0;
    wire [1:0] rdy, err, busy, sts;
    wire [31:0] pd [2];
    wire [7:0] map [2];
    wire [2:0] sel [2];
    wire [TW*32-1:0] act [2];
    logic [31:0] got [2];
    logic [1:0] gerr;
    int bad_count = 0;
    int check_count = 0;

    for (genvar i = 0; i < 2; i++)
    begin : g_port
        vcr_bank #(.IS_UPSTREAM(i == 0), .TBL_WORDS(TW), .TBL_RST(RST)) u_vcr_bank (.clk_sys(clk_sys),
            .resetn(resetn), .ce(ce), .apb_req(req), .pready(rdy[i]), .prdata(pd[i]), .pslverr(err[i]),
            .traffic_class_map(map[i]), .arb_scheme_select(sel[i]), .arb_table_active(act[i]),
            .arb_table_status(sts[i]), .load_busy(busy[i]));
    end

    initial
    begin
        forever #25 clk_sys = ~clk_sys;
    end

    task automatic conclude;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : conclude

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // Setup now, access next edge, hold until ready; no release so calls run back to back
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        req <= '{1'b1, 1'b0, w, a, d, s};
        @(posedge clk_sys);
        req.penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (rdy[0] !== 1'b1 && n < 20);
        if (n >= 20)
        begin
            bad_count++;
            conclude();
        end
        got[0] = pd[0];
        got[1] = pd[1];
        gerr = err;
    endtask : xfer

    task automatic idle(input int c);
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        repeat (c) @(posedge clk_sys);
    endtask : idle

    function automatic logic [31:0] ctl_exp(input logic [2:0] s, input logic [7:0] m);
        return {1'b1, 7'h00, 4'h0, s, 1'b0, 8'h00, m[7:1], 1'b1};
    endfunction : ctl_exp

    initial
    begin
        logic [31:0] v;
        logic [31:0] tw [TW];
        int n;
        void'($urandom(31));
        repeat (20) @(posedge clk_sys);
        resetn <= 1'b1;
        @(posedge clk_sys);
        xfer(1'b0, `VCR_CAP_OFF, 32'h0000_0000, 4'h0);
        chk("cap up", got[0], 32'h0200_0003);
        chk("cap dn", got[1], 32'h0000_0001);
        xfer(1'b0, `VCR_CTL_OFF, 32'h0000_0000, 4'h0);
        chk("ctl reset", got[0], ctl_exp(3'h0, 8'hFF));
        repeat (8)
        begin
            v = $urandom();
            v[16] = 1'b0;
            xfer(1'b1, `VCR_CTL_OFF, v, 4'hF);
            xfer(1'b0, `VCR_CTL_OFF, 32'h0000_0000, 4'h0);
            chk("ctl", got[0], ctl_exp(v[19:17], v[7:0]));
            chk("ctl dn", got[1], ctl_exp(v[19:17], v[7:0]));
            chk("sel port", 32'(sel[0]), 32'(v[19:17]));
            chk("map port", 32'(map[0]), 32'({v[7:1], 1'b1}));
        end
        xfer(1'b1, `VCR_CTL_OFF, 32'h0000_0000, 4'h1);
        xfer(1'b0, `VCR_CTL_OFF, 32'h0000_0000, 4'h0);
        chk("ctl lane0", got[0], ctl_exp(v[19:17], 8'h00));
        // Enable low over setup and the first two access cycles: the write waits, then lands
        ce <= 1'b0;
        fork
            xfer(1'b1, `VCR_CTL_OFF, 32'h000A_00F0, 4'hF);
            begin
                repeat (3) @(posedge clk_sys);
                ce <= 1'b1;
            end
        join
        xfer(1'b0, `VCR_CTL_OFF, 32'h0000_0000, 4'h0);
        chk("ctl after hold", got[0], ctl_exp(3'h5, 8'hF0));
        xfer(1'b0, 12'h300, 32'h0000_0000, 4'h0);
        chk("unmapped", {gerr[0], got[0][30:0]}, 32'h8000_0000);
        xfer(1'b1, `VCR_CTL_OFF, 32'h0000_00FF, 4'hF);
        for (int i = 0; i < TW; i++)
        begin
            tw[i] = $urandom();
            xfer(1'b1, `VCR_TBL_OFF + 12'(4 * i), tw[i], 4'hF);
            chk("dn table err", 32'(gerr[1]), 32'h0000_0001);
        end
        xfer(1'b0, `VCR_STS_OFF, 32'h0000_0000, 4'h0);
        chk("status up", got[0], 32'h0000_0001);
        chk("status dn", got[1], 32'h0000_0000);
        // Load with select 0 then select 1 without the trigger: neither may copy
        xfer(1'b1, `VCR_CTL_OFF, 32'h0001_00FF, 4'hF);
        xfer(1'b1, `VCR_CTL_OFF, 32'h0002_00FF, 4'hF);
        idle(TW + 4);
        chk("no load", act[0][31:0], RST);
        chk("status held", 32'(sts[0]), 32'h0000_0001);
        xfer(1'b1, `VCR_CTL_OFF, 32'h0003_00FF, 4'hF);
        n = 0;
        do
        begin
            xfer(1'b0, `VCR_STS_OFF, 32'h0000_0000, 4'h0);
            n++;
        end
        while (got[0][0] !== 1'b0 && n < 20);
        // Poll status until the arbiter has latched the table
        chk("status done", got[0], 32'h0000_0000);
        if (got[0][0] !== 1'b0)
            conclude();
        chk("busy end", 32'(busy[0]), 32'h0000_0000);
        for (int i = 0; i < TW; i++)
        begin
            chk("active up", act[0][32*i+:32], tw[i]);
            chk("active dn", act[1][32*i+:32], RST);
        end
        xfer(1'b0, `VCR_CTL_OFF, 32'h0000_0000, 4'h0);
        chk("load reads 0", got[0], ctl_exp(3'h1, 8'hFF));
        for (int i = 0; i < TW; i++)
        begin
            xfer(1'b0, `VCR_TBL_OFF + 12'(4 * i), 32'h0000_0000, 4'h0);
            chk("table up", got[0], tw[i]);
        end
        // Mid-run reset after a table write: status, control and arbiter copy return to reset
        xfer(1'b1, `VCR_TBL_OFF, 32'h0000_0000, 4'hF);
        xfer(1'b0, `VCR_STS_OFF, 32'h0000_0000, 4'h0);
        chk("status set 2", got[0], 32'h0000_0001);
        idle(1);
        resetn <= 1'b0;
        repeat (2) @(posedge clk_sys);
        resetn <= 1'b1;
        @(posedge clk_sys);
        xfer(1'b0, `VCR_STS_OFF, 32'h0000_0000, 4'h0);
        chk("status reset", got[0], 32'h0000_0000);
        xfer(1'b0, `VCR_CTL_OFF, 32'h0000_0000, 4'h0);
        chk("ctl reset 2", got[0], ctl_exp(3'h0, 8'hFF));
        chk("active reset", act[0][31:0], RST);
        idle(2);
        conclude();
    end
endmodule : tb
`default_nettype wire
